// ### core/gpm_params.svh
// Offsets, field positions, reset values and codes for the pin 7 output mux
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH
// Register index 0x17; its byte address is four times the index
`define GPM_IDX_PIN7_CTL 8'h17
`define GPM_ADDR_PIN7_CTL 10'h05c
`define GPM_RST_PIN7_CTL 8'h00
// Field positions
`define GPM_SEL_HI 7
`define GPM_SEL_LO 5
`define GPM_SRC_HI 4
`define GPM_SRC_LO 2
`define GPM_LVL_BIT 1
`define GPM_EN_BIT 0
// Source group codes
`define GPM_SRC_DEV 3'h4
`define GPM_SRC_RSV 3'h5
// AXI responses
`define GPM_RESP_OKAY 2'h0
`define GPM_RESP_SLVERR 2'h2
`endif

// ### core/gpm_pin7_mux.sv
// Output multiplexer and drive control for general purpose pin 7
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_pin7_mux
    import gpm_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Per receive port signals, index is the port number; rx_remote_gpio index is port times four plus the GPIO
    input wire logic [15:0] rx_remote_gpio,
    input wire logic [3:0] rx_lock,
    input wire logic [3:0] rx_pass,
    input wire logic [3:0] rx_frame_valid,
    input wire logic [3:0] rx_line_valid,
    input wire logic [3:0] rx_port_enabled,
    input wire logic camera_trigger_signal,
    // Per transmit port signals, index is the port number
    input wire logic [1:0] tx_pass_and,
    input wire logic [1:0] tx_pass_or,
    input wire logic [1:0] tx_frame_valid,
    input wire logic [1:0] tx_line_valid,
    input wire logic [1:0] tx_synchronized,
    input wire logic [1:0] tx_interrupt,
    // Pin driver
    output logic pin7_out,
    output logic pin7_oe
);

    // ==========================================================
    // Register bus
    // ==========================================================
    logic [7:0] ctl_reg; // Pin control register
    logic [7:0] ctl_next;
    logic aw_held_reg; // Write address captured
    logic [9:0] aw_addr_reg;
    logic w_held_reg; // Write data captured
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // Address match, low two bits ignored: word aligned registers
    function automatic logic hits_ctl(input logic [9:0] a);
        hits_ctl = (a[9:2] == 8'(`GPM_ADDR_PIN7_CTL >> 2));
    endfunction

    wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_hit = hits_ctl(aw_addr_reg);
    wire rd_hit = hits_ctl(s_axi_araddr);
    wire ar_take = s_axi_arvalid && s_axi_arready;

    // Accept each half once; hold until the response is issued
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // Only lane 0 carries the 8-bit register
    assign ctl_next = (wr_go && wr_hit && w_strb_reg[0]) ?
                      w_data_reg[7:0] : ctl_reg;

    // Write channel capture and response
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 10'h000;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `GPM_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                // Unmapped address answers SLVERR
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Control register; zero after reset
    always_ff @(posedge mclk)
    begin
        if (reset)
            ctl_reg <= `GPM_RST_PIN7_CTL;
        else
            ctl_reg <= ctl_next;
    end

    // Read channel: one cycle after address is taken
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `GPM_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
            rdata_reg <= rd_hit ? {24'h00_0000, ctl_reg} : 32'h0000_0000;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Output selection
    // ==========================================================
    wire [2:0] sel = ctl_reg[`GPM_SEL_HI:`GPM_SEL_LO];
    gpm_src_e src;
    assign src = gpm_src_e'(ctl_reg[`GPM_SRC_HI:`GPM_SRC_LO]);
    wire lvl = ctl_reg[`GPM_LVL_BIT];
    wire en = ctl_reg[`GPM_EN_BIT];
    wire [1:0] rxp = src[1:0];
    wire txp = src[0];

    // Combined lock and pass over enabled ports; no port enabled gives 0
    wire any_en = |rx_port_enabled;
    wire lock_or = |(rx_lock & rx_port_enabled);
    wire lock_and = any_en && &(rx_lock | ~rx_port_enabled);
    wire pass_and = any_en && &(rx_pass | ~rx_port_enabled);

    logic rx_val;
    logic dev_val;
    logic tx_val;
    logic sel_val;

    // Receive group choice
    always_comb
    begin
        rx_val = 1'b0;
        unique case (sel)
            3'h0, 3'h1, 3'h2, 3'h3:
                rx_val = rx_remote_gpio[{rxp, sel[1:0]}];
            3'h4: rx_val = rx_lock[rxp];
            3'h5: rx_val = rx_pass[rxp];
            3'h6: rx_val = rx_frame_valid[rxp];
            3'h7: rx_val = rx_line_valid[rxp];
        endcase
    end

    // Device status choice; reserved codes give low
    always_comb
    begin
        dev_val = 1'b0;
        unique case (sel)
            3'h0: dev_val = lvl;
            3'h1: dev_val = lock_or;
            3'h2: dev_val = lock_and;
            3'h3: dev_val = pass_and;
            3'h4: dev_val = camera_trigger_signal;
            3'h5, 3'h6, 3'h7: dev_val = 1'b0;
        endcase
    end

    // Transmit port choice; code 6 unlisted, 7 reserved, both low
    always_comb
    begin
        tx_val = 1'b0;
        unique case (sel)
            3'h0: tx_val = tx_pass_and[txp];
            3'h1: tx_val = tx_pass_or[txp];
            3'h2: tx_val = tx_frame_valid[txp];
            3'h3: tx_val = tx_line_valid[txp];
            3'h4: tx_val = tx_synchronized[txp];
            3'h5: tx_val = tx_interrupt[txp];
            3'h6, 3'h7: tx_val = 1'b0;
        endcase
    end

    // Group choice; reserved group gives low
    always_comb
    begin
        sel_val = 1'b0;
        unique case (src)
            GPM_RX0, GPM_RX1, GPM_RX2, GPM_RX3: sel_val = rx_val;
            GPM_DEV: sel_val = dev_val;
            GPM_RSV: sel_val = 1'b0;
            GPM_TX0, GPM_TX1: sel_val = tx_val;
        endcase
    end

    // Registered pin data; low from one cycle after en clears so it never floats odd
    logic pin_reg;
    always_ff @(posedge mclk)
    begin
        if (reset)
            pin_reg <= 1'b0;
        else
            pin_reg <= en & sel_val;
    end
    assign pin7_out = pin_reg;
    assign pin7_oe = en;

    // ==========================================================
    // Checks
    // ==========================================================
    // All checks sample on mclk and rest while reset is high
    default clocking chk_cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    chk_enable_gates: assert property (wr_go && wr_hit &&
        w_strb_reg[0] |=> pin7_oe == $past(w_data_reg[0]))
        else $error("drive enable does not follow written bit");
    chk_reset_zero: assert property ($past(reset) |->
        ctl_reg == `GPM_RST_PIN7_CTL && !pin7_oe)
        else $error("control not zero after reset");
    chk_sw_level: assert property ((ctl_reg[7:2] == 6'h04 && en) ##1
        $stable(ctl_reg) |-> pin7_out == $past(lvl))
        else $error("software level not on pin");
    chk_rsv_group: assert property (
        ctl_reg[4:2] == `GPM_SRC_RSV |=> !pin7_out)
        else $error("reserved group not low");
    chk_dev_rsv: assert property (
        ctl_reg[4:2] == `GPM_SRC_DEV && sel >= 3'h5 |=> !pin7_out)
        else $error("reserved status code not low");
    chk_rx_lock: assert property (!src[2] && sel == 3'h4 && en |=>
        pin7_out == $past(rx_lock[rxp]))
        else $error("lock not routed");
    chk_rx_gpio: assert property (!src[2] && !sel[2] && en |=>
        pin7_out == $past(rx_remote_gpio[{rxp, sel[1:0]}]))
        else $error("remote level not routed");
    chk_tx_int: assert property (src[2:1] == 2'h3 && sel == 3'h5
        && en |=> pin7_out == $past(tx_interrupt[txp]))
        else $error("transmit interrupt not routed");
    chk_lock_or: assert property (src == GPM_DEV && sel == 3'h1
        && en |=> pin7_out == $past(lock_or))
        else $error("lock OR not routed");
    chk_wr_resp: assert property (wr_go |=> s_axi_bvalid)
        else $error("write response missing");
    cov_write: cover property (@(posedge mclk) wr_go && wr_hit);
    cov_read: cover property (@(posedge mclk) ar_take && rd_hit);
    cov_dev: cover property (@(posedge mclk) src == GPM_DEV && en);
    cov_tx: cover property (@(posedge mclk) src == GPM_TX1 && en);

endmodule

// ### core/gpm_pkg.sv
// Types shared by the pin 7 output mux
package gpm_pkg;
    // Source group selection
    typedef enum logic [2:0]
    {
        GPM_RX0 = 3'h0,
        GPM_RX1 = 3'h1,
        GPM_RX2 = 3'h2,
        GPM_RX3 = 3'h3,
        GPM_DEV = 3'h4,
        GPM_RSV = 3'h5,
        GPM_TX0 = 3'h6,
        GPM_TX1 = 3'h7
    } gpm_src_e;
endpackage

// ### testbench/gpm_pin_load.sv
// Board-side load on pin 7: a weak pull-down behind the pad
`timescale 1ns/1ps
module gpm_pin_load
(
    input wire logic pin7_out,
    input wire logic pin7_oe,
    output logic pad_level
);
    // ==========================================
    // Pad resolution
    // An undriven pad falls to the pull-down, never to a stale value
    assign pad_level = pin7_oe ? pin7_out : 1'b0;
endmodule

// ### testbench/tb_gpm_pin7_mux.sv
// Self-checking bench for the pin 7 output mux
`timescale 1ns/1ps
`include "gpm_params.svh"
module tb_gpm_pin7_mux;
    // ==========================================
    // Signals
    logic mclk = 0, reset = 1, chk_pin = 0;
    logic [9:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, pin7_out, pin7_oe, pad;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] rg = 0;
    logic [3:0] lk = 0, pa = 0, fv = 0, lv = 0, en = 0;
    logic trig = 0;
    logic [1:0] tpa = 0, tpo = 0, tfv = 0, tlv = 0, tsy = 0, tin = 0;
    logic [33:0] bq[$], rq[$], pq[$]; // Expected results, oldest first
    logic [63:0] rv;
    int num_errors = 0, tests_run = 0, i;
    integer seed = 32'h0000_14c2;

    // ==========================================
    // Design and pin load
    gpm_pin7_mux i_dut (.mclk(mclk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_remote_gpio(rg), .rx_lock(lk),
        .rx_pass(pa), .rx_frame_valid(fv), .rx_line_valid(lv),
        .rx_port_enabled(en), .camera_trigger_signal(trig),
        .tx_pass_and(tpa), .tx_pass_or(tpo), .tx_frame_valid(tfv),
        .tx_line_valid(tlv), .tx_synchronized(tsy), .tx_interrupt(tin),
        .pin7_out(pin7_out), .pin7_oe(pin7_oe));
    gpm_pin_load i_load (.pin7_out(pin7_out), .pin7_oe(pin7_oe),
        .pad_level(pad));

    // ==========================================
    // Clock: 100 ns period
    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // ==========================================
    // Verdict and comparison helpers
    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A wait that ran out counts as a mismatch and ends the run
    task automatic hang();
        num_errors++;
        $display("MISMATCH %0t bus wait ran out", $time);
        give_verdict();
    endtask

    // Fresh random levels on every source, driven just after an edge
    task automatic shake();
        rv = {$random(seed), $random(seed)};
        {rg, lk, pa, fv, lv, en, trig, tpa, tpo, tfv, tlv, tsy, tin}
            <= rv[48:0];
    endtask

    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Selected value worked out from the code tables
    function automatic logic pick(input logic [7:0] c);
        logic [7:0] rxv, dv, tv;
        logic [1:0] p;
        p = c[3:2];
        rxv = {lv[p], fv[p], pa[p], lk[p], rg[{p, 2'b00} +: 4]};
        dv = {3'h0, trig, (en != 0) && &(pa | ~en),
            (en != 0) && &(lk | ~en), |(lk & en), c[1]};
        tv = {2'h0, tin[c[2]], tsy[c[2]], tlv[c[2]], tfv[c[2]],
            tpo[c[2]], tpa[c[2]]};
        // Reserved group and reserved codes hold the pin low
        case (c[4:2])
            3'h4: return dv[c[7:5]];
            3'h5: return 1'b0;
            3'h6, 3'h7: return tv[c[7:5]];
            default: return rxv[c[7:5]];
        endcase
    endfunction

    // ==========================================
    // Bus and pin drivers; each starts one edge after the last ended
    task automatic wr(input logic [9:0] a, input logic [7:0] d,
        input logic [3:0] s, input logic [1:0] r);
        int n;
        @(posedge mclk);
        bq.push_back({32'h0000_0000, r});
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            // Release each channel once it was taken
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            n++;
        end
        while (!bvalid && n < 50);
        bready <= 1'b0;
        if (n >= 50)
            hang();
    endtask

    task automatic rd(input logic [9:0] a, input logic [33:0] e);
        int n;
        @(posedge mclk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'b0;
            n++;
        end
        while (!rvalid && n < 50);
        rready <= 1'b0;
        if (n >= 50)
            hang();
    endtask

    // Pin is looked at on the second edge after the previous task ended
    task automatic pin_check(input logic [7:0] c);
        @(posedge mclk);
        pq.push_back({32'h0000_0000, c[0], c[0] & pick(c)});
        chk_pin <= 1'b1;
        @(posedge mclk);
        chk_pin <= 1'b0;
    endtask

    // ==========================================
    // Monitor: pops the oldest note whenever a result shows
    always @(posedge mclk)
    begin
        if (bvalid && bready)
            cmp(bq.pop_front(), {32'h0000_0000, bresp});
        if (rvalid && rready)
            cmp(rq.pop_front(), {rresp, rdata});
        if (chk_pin)
            cmp(pq.pop_front(), {32'h0000_0000, pin7_oe, pad});
    end

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd(`GPM_ADDR_PIN7_CTL, 34'h0_0000_0000);
        pin_check(8'h00);
        // Every control code, with random levels on all sources
        for (i = 0; i < 256; i++)
        begin
            shake();
            wr(`GPM_ADDR_PIN7_CTL, i[7:0], 4'hf, `GPM_RESP_OKAY);
            rd(`GPM_ADDR_PIN7_CTL, {`GPM_RESP_OKAY, 24'h00_0000, i[7:0]});
            pin_check(i[7:0]);
            // Sources move while the control word stays put
            shake();
            pin_check(i[7:0]);
        end
        // Lane 0 not strobed, so the register keeps its value
        wr(`GPM_ADDR_PIN7_CTL, 8'h00, 4'he, `GPM_RESP_OKAY);
        rd(`GPM_ADDR_PIN7_CTL, {`GPM_RESP_OKAY, 32'h0000_00ff});
        // Unmapped word: error answer, no side effect
        wr(10'h060, 8'h5a, 4'hf, `GPM_RESP_SLVERR);
        rd(10'h060, {`GPM_RESP_SLVERR, 32'h0000_0000});
        rd(`GPM_ADDR_PIN7_CTL, {`GPM_RESP_OKAY, 32'h0000_00ff});
        // Second reset in mid-run clears the control word
        @(posedge mclk);
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        rd(`GPM_ADDR_PIN7_CTL, 34'h0_0000_0000);
        pin_check(8'h00);
        // Let the monitor take the last note before judging
        @(posedge mclk);
        if (bq.size() + rq.size() + pq.size() != 0)
        begin
            num_errors++;
            $display("MISMATCH %0t results left unchecked", $time);
        end
        give_verdict();
    end
endmodule
